// >>> design/fp_add_abs_compare_datapath.sv
// FP datapath slice: absolute value, add, ordered compare, Wishbone registers
// Summary of operation
// RL1 - Absolute value clears sign bit only
// RL2 - Shift smaller-exponent significand right until equal
// RL3 - Add or subtract significands by operand signs
// RL4 - Carry 53 significand bits plus guard, round, sticky
// RL5 - Carry out: shift right, exponent plus one
// RL6 - Normalize when leading bit is not one
// RL7 - Round to double or single per mode
// RL8 - Class flags updated unless trapped invalid
// RL9 - Record bit copies summary bits to field one
// RL10 - Compare codes less, greater, equal to fields
// RL11 - Any NaN operand gives unordered code
// RL12 - Signaling NaN sets flags; compare flag if disabled
// RL13 - Quiet NaN only sets invalid compare flag
// RL14 - Record bit clear leaves field one alone
// RL15 - Unordered code is 0001
`include "fp_datapath_defines.svh"
module fp_add_abs_compare_datapath (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Wishbone slave
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_wr,
	output logic      [31:0] wb_dat_rd,
	output logic             wb_ack,
	// Interrupt
	output logic             irq
);
	// ============================================================
	// Helper functions
	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				o[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return o;
	endfunction
	// Significand with hidden bit and three low guard positions
	function automatic logic [56:0] sig_of(input logic [63:0] v);
		return {1'b0, |v[62:52], v[51:0], 3'h0}; // RL4
	endfunction
	// Denormals use the minimum exponent
	function automatic logic [12:0] exp_of(input logic [63:0] v);
		return (v[62:52] == 11'h000) ? 13'h0001 : {2'h0, v[62:52]};
	endfunction
	function automatic logic is_nan(input logic [63:0] v);
		return (&v[62:52]) & (|v[51:0]);
	endfunction
	function automatic logic is_snan(input logic [63:0] v);
		return is_nan(v) & ~v[`QUIET_BIT];
	endfunction
	function automatic logic is_inf(input logic [63:0] v);
		return (&v[62:52]) & ~(|v[51:0]);
	endfunction
	// Ordered less-than; both zeros compare equal
	function automatic logic less(input logic [63:0] a, input logic [63:0] b);
		if (~(|a[62:0]) && ~(|b[62:0])) begin
			return 1'b0;
		end else if (a[63] != b[63]) begin
			return a[63];
		end
		return a[63] ? (a[62:0] > b[62:0]) : (a[62:0] < b[62:0]);
	endfunction
	// Result class code from sign and kind
	function automatic logic [4:0] cls(input logic s, input logic z, input logic d, input logic f);
		if (f) begin
			return s ? `CL_NINF : `CL_PINF;
		end else if (z) begin
			return s ? `CL_NZERO : `CL_PZERO;
		end else if (d) begin
			return s ? `CL_NDEN : `CL_PDEN;
		end
		return s ? `CL_NNORM : `CL_PNORM;
	endfunction

	// ============================================================
	// Registers
	logic [63:0]                  opa_q, opb_q, res_q;  // Operands and result
	logic [31:0]                  fp_status_control_reg_q, fp_status_control_reg_d;     // Status and control
	logic [31:0]                  cr_q, cr_d;           // Condition fields
	logic [1:0]                   irq_st_q, irq_mask_q; // Interrupt status and mask
	logic                         ack_q, irq_q;
	logic [31:0]                  rd_q;
	fp_datapath_pkg::state_t      state_q;
	fp_datapath_pkg::op_t         op_q;
	logic                         rec_q;                // Record bit
	logic [2:0]                   tgt_q;                // Compare target field
	logic                         xs_q, ys_q, sgn_q;    // Signs
	logic [12:0]                  xe_q, ye_q, re_q;     // Exponents
	logic [56:0]                  xm_q, ym_q, sm_q;     // Significands
	logic [4:0]                   cls_q;                // Pending class
	logic                         cls_ok_q;             // Class may be written
	logic [3:0]                   cc_q;                 // Pending compare code
	logic                         cc_wr_q;
	logic                         ev_snan_q, ev_isi_q, ev_vc_q, ev_ox_q;

	// Bus decode: a request is taken once, the cycle before ack
	logic        req, wr;
	logic        start;
	logic        ve;
	logic [1:0]  rn;
	assign req   = wb_cyc & wb_stb & ~ack_q;
	assign wr    = req & wb_we;
	assign start = wr & (wb_adr == `OFS_CMD) & (state_q == fp_datapath_pkg::ST_IDLE);
	assign ve    = fp_status_control_reg_q[`VE_BIT];
	assign rn    = fp_status_control_reg_q[`RN_HI:`RN_LO];

	assign wb_ack    = ack_q;
	assign wb_dat_rd = rd_q;
	assign irq       = irq_q;

	// ============================================================
	// Wishbone answer: ack one cycle after the request, then drop
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
			rd_q  <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req && !wb_we) begin
				unique case (wb_adr)
					`OFS_OPA_HI:   rd_q <= opa_q[63:32];
					`OFS_OPA_LO:   rd_q <= opa_q[31:0];
					`OFS_OPB_HI:   rd_q <= opb_q[63:32];
					`OFS_OPB_LO:   rd_q <= opb_q[31:0];
					`OFS_RES_HI:   rd_q <= res_q[63:32];
					`OFS_RES_LO:   rd_q <= res_q[31:0];
					`OFS_FP_STATUS_CONTROL_REG:    rd_q <= fp_status_control_reg_q;
					`OFS_CR:       rd_q <= cr_q;
					`OFS_STAT:     rd_q <= {28'h0, state_q, state_q != fp_datapath_pkg::ST_IDLE};
					`OFS_IRQ_ST:   rd_q <= {30'h0, irq_st_q};
					`OFS_IRQ_MASK: rd_q <= {30'h0, irq_mask_q};
					// Unmapped and write-only addresses read zero
					default:       rd_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Operand registers, writable at any time
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			opa_q <= 64'h0;
			opb_q <= 64'h0;
		end else if (wr) begin
			if (wb_adr == `OFS_OPA_HI) opa_q[63:32] <= merge(opa_q[63:32], wb_dat_wr, wb_sel);
			if (wb_adr == `OFS_OPA_LO) opa_q[31:0]  <= merge(opa_q[31:0], wb_dat_wr, wb_sel);
			if (wb_adr == `OFS_OPB_HI) opb_q[63:32] <= merge(opb_q[63:32], wb_dat_wr, wb_sel);
			if (wb_adr == `OFS_OPB_LO) opb_q[31:0]  <= merge(opb_q[31:0], wb_dat_wr, wb_sel);
		end
	end

	// ============================================================
	// Rounding of the normalized sum
	logic [5:0]  rp;
	logic [56:0] lm, rs;
	logic        rb, st, inc, ovf, dbl;
	logic [12:0] re2;
	logic [63:0] rres;
	always_comb begin
		dbl = (op_q == fp_datapath_pkg::OP_ADD);
		rp  = dbl ? `LSB_DBL : `LSB_SGL; // RL7
		lm  = 57'h1 << rp;
		rb  = |(sm_q & (lm >> 1));
		st  = |(sm_q & ((lm >> 1) - 57'h1));
		unique case (rn)
			`RN_NEAR: inc = rb & (st | (|(sm_q & lm))); // RL7
			`RN_ZERO: inc = 1'b0;
			`RN_PINF: inc = ~sgn_q & (rb | st);
			`RN_NINF: inc = sgn_q & (rb | st);
		endcase
		rs  = (sm_q & ~(lm - 57'h1)) + (inc ? lm : 57'h0);
		re2 = re_q;
		// Rounding may carry into a new leading bit
		if (rs[`SIG_C]) begin
			rs  = rs >> 1;
			re2 = re_q + 13'h0001;
		end
		ovf  = re2 > (dbl ? `EXP_DBL_MAX : `EXP_SGL_MAX);
		// Overflow always goes to infinity; max-finite modes are not modelled
		rres = ovf ? {sgn_q, `INF_EXP, 52'h0} : {sgn_q, rs[`SIG_H] ? re2[10:0] : 11'h000, rs[54:3]};
	end

	// ============================================================
	// Sequencer and datapath
	logic        na, nb, sa, sb, inv;
	fp_datapath_pkg::op_t cop;
	assign na  = is_nan(opa_q);
	assign nb  = is_nan(opb_q);
	assign sa  = is_snan(opa_q);
	assign sb  = is_snan(opb_q);
	assign cop = fp_datapath_pkg::op_t'(wb_dat_wr[`CMD_OP_HI:`CMD_OP_LO]);
	assign inv = sa | sb | (is_inf(opa_q) & is_inf(opb_q) & (opa_q[63] ^ opb_q[63]));

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= fp_datapath_pkg::ST_IDLE;
			op_q <= fp_datapath_pkg::OP_ABS;
			{rec_q, tgt_q, xs_q, ys_q, sgn_q} <= 7'h00;
			{xe_q, ye_q, re_q} <= 39'h0;
			{xm_q, ym_q, sm_q} <= 171'h0;
			res_q <= 64'h0;
			{cls_q, cls_ok_q, cc_q, cc_wr_q} <= 11'h000;
			{ev_snan_q, ev_isi_q, ev_vc_q, ev_ox_q} <= 4'h0;
		end else begin
			unique case (state_q)
				fp_datapath_pkg::ST_IDLE: begin
					if (start) begin
						op_q  <= cop;
						rec_q <= wb_dat_wr[`CMD_REC] & (cop != fp_datapath_pkg::OP_CMPO);
						tgt_q <= wb_dat_wr[`CMD_TGT_HI:`CMD_TGT_LO];
						{cls_ok_q, cc_wr_q, ev_isi_q, ev_vc_q, ev_ox_q} <= 5'h00;
						ev_snan_q <= (na | nb | cop == fp_datapath_pkg::OP_CMPO) & (sa | sb);
						state_q <= fp_datapath_pkg::ST_DONE;
						unique case (cop)
							fp_datapath_pkg::OP_ABS: begin
								res_q <= {1'b0, opb_q[62:0]}; // RL1
							end
							fp_datapath_pkg::OP_CMPO: begin
								cc_wr_q <= 1'b1;
								if (na | nb) cc_q <= `CC_UN; // RL11 RL15
								else if (less(opa_q, opb_q)) cc_q <= `CC_LT; // RL10
								else if (less(opb_q, opa_q)) cc_q <= `CC_GT; // RL10
								else cc_q <= `CC_EQ; // RL10
								ev_vc_q <= (sa | sb) ? ~ve : (na | nb); // RL12 RL13
							end
							fp_datapath_pkg::OP_ADD, fp_datapath_pkg::OP_ADDS: begin
								// Specials bypass the adder; trapped invalid leaves result alone
								cls_ok_q <= ~(inv & ve); // RL8
								ev_isi_q <= inv & ~sa & ~sb;
								if (na | nb) begin
									if (!ve || !inv) res_q <= (na ? opa_q : opb_q) | (64'h1 << `QUIET_BIT);
									cls_q <= `CL_QNAN;
								end else if (inv) begin
									if (!ve) res_q <= `QNAN_DEF;
									cls_q <= `CL_QNAN;
								end else if (is_inf(opa_q) || is_inf(opb_q)) begin
									res_q <= is_inf(opa_q) ? opa_q : opb_q;
									cls_q <= cls(is_inf(opa_q) ? opa_q[63] : opb_q[63], 1'b0, 1'b0, 1'b1);
								end else begin
									// Larger exponent goes to x, smaller to y
									if (exp_of(opa_q) >= exp_of(opb_q)) begin
										{xs_q, xe_q, xm_q} <= {opa_q[63], exp_of(opa_q), sig_of(opa_q)};
										{ys_q, ye_q, ym_q} <= {opb_q[63], exp_of(opb_q), sig_of(opb_q)};
									end else begin
										{xs_q, xe_q, xm_q} <= {opb_q[63], exp_of(opb_q), sig_of(opb_q)};
										{ys_q, ye_q, ym_q} <= {opa_q[63], exp_of(opa_q), sig_of(opa_q)};
									end
									state_q <= fp_datapath_pkg::ST_ALIGN;
								end
							end
						endcase
					end
				end
				fp_datapath_pkg::ST_ALIGN: begin
					// One bit per cycle; a far shift collapses straight into sticky
					if (ye_q < xe_q) begin
						if ((xe_q - ye_q) > `ALIGN_LIMIT) begin
							ym_q <= {56'h0, |ym_q}; // RL2
							ye_q <= xe_q;
						end else begin
							ym_q <= {1'b0, ym_q[56:2], ym_q[1] | ym_q[0]}; // RL2 RL4
							ye_q <= ye_q + 13'h0001; // RL2
						end
					end else begin
						state_q <= fp_datapath_pkg::ST_ADDSUB;
					end
				end
				fp_datapath_pkg::ST_ADDSUB: begin
					re_q <= xe_q;
					if (xs_q == ys_q) begin
						sm_q  <= xm_q + ym_q; // RL3
						sgn_q <= xs_q;
					end else if (xm_q >= ym_q) begin
						sm_q  <= xm_q - ym_q; // RL3
						// Exact cancellation is positive except when rounding down
						sgn_q <= (xm_q == ym_q) ? (rn == `RN_NINF) : xs_q;
					end else begin
						sm_q  <= ym_q - xm_q; // RL3
						sgn_q <= ys_q;
					end
					state_q <= fp_datapath_pkg::ST_NORM;
				end
				fp_datapath_pkg::ST_NORM: begin
					if (sm_q[`SIG_C]) begin
						sm_q <= {1'b0, sm_q[56:2], sm_q[1] | sm_q[0]}; // RL5
						re_q <= re_q + 13'h0001; // RL5
					end else if (!sm_q[`SIG_H] && (sm_q != 57'h0) && (re_q > 13'h0001)) begin
						sm_q <= sm_q << 1; // RL6
						re_q <= re_q - 13'h0001; // RL6
					end else begin
						state_q <= fp_datapath_pkg::ST_ROUND;
					end
				end
				fp_datapath_pkg::ST_ROUND: begin
					res_q    <= rres; // RL7
					cls_q    <= cls(sgn_q, rs == 57'h0, ~rs[`SIG_H], ovf); // RL8
					cls_ok_q <= 1'b1; // RL8
					ev_ox_q  <= ovf;
					state_q  <= fp_datapath_pkg::ST_DONE;
				end
				fp_datapath_pkg::ST_DONE: begin
					state_q <= fp_datapath_pkg::ST_IDLE;
				end
				// Unused codes fall back to idle
				default: begin
					state_q <= fp_datapath_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// Status register update: software write first, events on top
	logic fp_status_control_reg_wr, cr_wr, done;
	assign fp_status_control_reg_wr = wr & (wb_adr == `OFS_FP_STATUS_CONTROL_REG);
	assign cr_wr    = wr & (wb_adr == `OFS_CR);
	assign done     = (state_q == fp_datapath_pkg::ST_DONE);
	always_comb begin
		fp_status_control_reg_d = fp_status_control_reg_wr ? merge(fp_status_control_reg_q, wb_dat_wr, wb_sel) : fp_status_control_reg_q;
		if (done) begin
			// New exceptions raise the summary; set wins over a clearing write
			if ((ev_snan_q & ~fp_status_control_reg_d[`SIGNALING_NAN_INVALID_FLAG_BIT]) | (ev_isi_q & ~fp_status_control_reg_d[`VXISI_BIT]) |
			    (ev_vc_q & ~fp_status_control_reg_d[`INVALID_COMPARE_FLAG_BIT]) | (ev_ox_q & ~fp_status_control_reg_d[`OX_BIT])) begin
				fp_status_control_reg_d[`FX_BIT] = 1'b1;
			end
			fp_status_control_reg_d[`SIGNALING_NAN_INVALID_FLAG_BIT] = fp_status_control_reg_d[`SIGNALING_NAN_INVALID_FLAG_BIT] | ev_snan_q; // RL12
			fp_status_control_reg_d[`VXISI_BIT]  = fp_status_control_reg_d[`VXISI_BIT] | ev_isi_q;
			fp_status_control_reg_d[`INVALID_COMPARE_FLAG_BIT]   = fp_status_control_reg_d[`INVALID_COMPARE_FLAG_BIT] | ev_vc_q; // RL12 RL13
			fp_status_control_reg_d[`OX_BIT]     = fp_status_control_reg_d[`OX_BIT] | ev_ox_q;
			if (cls_ok_q) fp_status_control_reg_d[`RESULT_CLASS_FLAGS_HI:`RESULT_CLASS_FLAGS_LO] = cls_q; // RL8
			if (cc_wr_q) fp_status_control_reg_d[`FP_CONDITION_CODE_HI:`RESULT_CLASS_FLAGS_LO] = cc_q; // RL10 RL11
		end
		// VX and FEX always follow their sources
		fp_status_control_reg_d[`VX_BIT]  = fp_status_control_reg_d[`SIGNALING_NAN_INVALID_FLAG_BIT] | fp_status_control_reg_d[`VXISI_BIT] | fp_status_control_reg_d[`INVALID_COMPARE_FLAG_BIT];
		fp_status_control_reg_d[`FEX_BIT] = fp_status_control_reg_d[`VX_BIT] & fp_status_control_reg_d[`VE_BIT];
	end

	// Condition fields: compare target and record copy
	always_comb begin
		cr_d = cr_wr ? merge(cr_q, wb_dat_wr, wb_sel) : cr_q;
		if (done && cc_wr_q) begin
			cr_d[5'(31 - {tgt_q, 2'h0}) -: 4] = cc_q; // RL10 RL11
		end
		if (done && rec_q) begin
			cr_d[`CR1_HI:`CR1_LO] = {fp_status_control_reg_d[`FX_BIT], fp_status_control_reg_d[`FEX_BIT], fp_status_control_reg_d[`VX_BIT], fp_status_control_reg_d[`OX_BIT]}; // RL9
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fp_status_control_reg_q <= `FP_STATUS_CONTROL_REG_RST;
			cr_q    <= `CR_RST;
		end else begin
			fp_status_control_reg_q <= fp_status_control_reg_d;
			cr_q    <= cr_d; // RL14
		end
	end

	// ============================================================
	// Interrupt: sticky events, write one to clear, set wins
	logic [1:0] irq_st_d;
	always_comb begin
		irq_st_d = irq_st_q;
		if (wr && wb_adr == `OFS_IRQ_ST) irq_st_d = irq_st_q & ~(wb_sel[0] ? wb_dat_wr[1:0] : 2'h0);
		if (done) begin
			irq_st_d[`IRQ_DONE] = 1'b1;
			irq_st_d[`IRQ_INV]  = irq_st_d[`IRQ_INV] | ev_snan_q | ev_isi_q | ev_vc_q;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_st_q   <= 2'h0;
			irq_mask_q <= 2'h0;
			irq_q      <= 1'b0;
		end else begin
			irq_st_q <= irq_st_d;
			if (wr && wb_adr == `OFS_IRQ_MASK && wb_sel[0]) irq_mask_q <= wb_dat_wr[1:0];
			irq_q <= |(irq_st_d & irq_mask_q);
		end
	end

	// ============================================================
	// Checks
	abs_sign_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL1
		start && cop == fp_datapath_pkg::OP_ABS |=> res_q == {1'b0, $past(opb_q[62:0])})
		else $error("abs result wrong");
	align_step_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL2
		state_q == fp_datapath_pkg::ST_ALIGN && ye_q < xe_q && (xe_q - ye_q) <= `ALIGN_LIMIT
		|=> ye_q == $past(ye_q) + 13'h0001 && xe_q == $past(xe_q))
		else $error("alignment step wrong");
	align_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL2
		state_q == fp_datapath_pkg::ST_ALIGN && ye_q == xe_q |=> state_q == fp_datapath_pkg::ST_ADDSUB)
		else $error("alignment did not finish");
	carry_shift_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL5
		state_q == fp_datapath_pkg::ST_NORM && sm_q[`SIG_C] |=> re_q == $past(re_q) + 13'h0001 && !sm_q[`SIG_C])
		else $error("carry not handled");
	norm_lead_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL6
		state_q == fp_datapath_pkg::ST_ROUND |-> !sm_q[`SIG_C] && (sm_q[`SIG_H] || re_q == 13'h0001 || sm_q == 57'h0))
		else $error("sum not normalized");
	cmp_unord_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL11
		start && cop == fp_datapath_pkg::OP_CMPO && (na || nb) |=> ##1 fp_status_control_reg_q[`FP_CONDITION_CODE_HI:`RESULT_CLASS_FLAGS_LO] == `CC_UN)
		else $error("unordered code missing");
	snan_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL12
		done && ev_snan_q |=> fp_status_control_reg_q[`SIGNALING_NAN_INVALID_FLAG_BIT] && fp_status_control_reg_q[`VX_BIT])
		else $error("signaling flag not set");
	rec_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL9
		done && rec_q |=> cr_q[`CR1_HI:`CR1_LO] == fp_status_control_reg_q[`FX_BIT:`OX_BIT])
		else $error("record copy wrong");
	rec_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL14
		done && !rec_q && !cc_wr_q && !cr_wr |=> $stable(cr_q))
		else $error("condition field changed");
endmodule

// >>> design/fp_datapath_defines.svh
// Register offsets, field positions, codes and reset values of the FP datapath slice
`ifndef FP_DATAPATH_DEFINES_SVH
`define FP_DATAPATH_DEFINES_SVH
// ============================================================
// Register byte offsets
`define OFS_OPA_HI   8'h00
`define OFS_OPA_LO   8'h04
`define OFS_OPB_HI   8'h08
`define OFS_OPB_LO   8'h0C
`define OFS_CMD      8'h10
`define OFS_RES_HI   8'h14
`define OFS_RES_LO   8'h18
`define OFS_FP_STATUS_CONTROL_REG    8'h1C
`define OFS_CR       8'h20
`define OFS_STAT     8'h24
`define OFS_IRQ_ST   8'h28
`define OFS_IRQ_MASK 8'h2C
// ============================================================
// Command word fields
`define CMD_OP_HI    1
`define CMD_OP_LO    0
`define CMD_REC      2
`define CMD_TGT_HI   6
`define CMD_TGT_LO   4
// ============================================================
// Status and control register fields
`define FX_BIT       31
`define FEX_BIT      30
`define VX_BIT       29
`define OX_BIT       28
`define SIGNALING_NAN_INVALID_FLAG_BIT   24
`define VXISI_BIT    23
`define INVALID_COMPARE_FLAG_BIT     19
`define RESULT_CLASS_FLAGS_HI      16
`define RESULT_CLASS_FLAGS_LO      12
`define FP_CONDITION_CODE_HI      15
`define VE_BIT       7
`define RN_HI        1
`define RN_LO        0
`define CR1_HI       27
`define CR1_LO       24
`define FP_STATUS_CONTROL_REG_RST    32'h0000_0000
`define CR_RST       32'h0000_0000
// ============================================================
// Compare codes and result classes
`define CC_LT        4'h8
`define CC_GT        4'h4
`define CC_EQ        4'h2
`define CC_UN        4'h1
`define CL_PNORM     5'h04
`define CL_NNORM     5'h08
`define CL_PZERO     5'h02
`define CL_NZERO     5'h12
`define CL_PINF      5'h05
`define CL_NINF      5'h09
`define CL_QNAN      5'h11
`define CL_PDEN      5'h14
`define CL_NDEN      5'h18
// ============================================================
// Rounding modes, exponent limits, significand layout
`define RN_NEAR      2'h0
`define RN_ZERO      2'h1
`define RN_PINF      2'h2
`define RN_NINF      2'h3
`define EXP_DBL_MAX  13'h07FE
`define EXP_SGL_MAX  13'h047E
`define ALIGN_LIMIT  13'h0038
`define INF_EXP      11'h7FF
`define QNAN_DEF     64'h7FF8_0000_0000_0000
`define QUIET_BIT    51
`define LSB_DBL      6'h03
`define LSB_SGL      6'h20
`define SIG_C        56
`define SIG_H        55
`define IRQ_DONE     0
`define IRQ_INV      1
`endif

// >>> design/fp_datapath_pkg.sv
// Types shared by the FP datapath slice
package fp_datapath_pkg;
	// Operation codes carried in the command word
	typedef enum logic [1:0] {
		OP_ABS  = 2'h0,
		OP_ADD  = 2'h1,
		OP_ADDS = 2'h2,
		OP_CMPO = 2'h3
	} op_t;
	// Sequencer states, Gray coded along the add path
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_ALIGN  = 3'h1,
		ST_ADDSUB = 3'h3,
		ST_NORM   = 3'h2,
		ST_ROUND  = 3'h6,
		ST_DONE   = 3'h7
	} state_t;
endpackage

// >>> dv/seq_bus_model.sv
// Sequencer-side model that issues classic single Wishbone cycles
module seq_bus_model (
	// Clock
	input  wire logic        sys_clk,
	// Wishbone master side
	output logic             wb_cyc,
	output logic             wb_stb,
	output logic             wb_we,
	output logic [7:0]       wb_adr,
	output logic [3:0]       wb_sel,
	output logic [31:0]      wb_dat_wr,
	input  wire logic [31:0] wb_dat_rd,
	input  wire logic        wb_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'hF;
		wb_dat_wr = 32'h0000_0000;
	end
	// One cycle; gap idles model a slow sequencer, held until ack is seen
	task automatic xfer(input int gap, input logic we, input logic [7:0] adr,
		input logic [31:0] dat, output logic [31:0] rd);
		repeat (gap + 1) @(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat_wr <= dat;
		// No limit of its own: only the bench watchdog ends a hung wait
		do begin
			@(posedge sys_clk);
		end while (wb_ack !== 1'b1);
		rd = wb_dat_rd;
		// Released data goes to its inverse so stale values never look valid
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_dat_wr <= ~dat;
	endtask
endmodule

// >>> dv/test_fp_add_abs_compare_datapath.sv
// Self-checking testbench of the FP datapath slice
`include "fp_datapath_defines.svh"
module test_fp_add_abs_compare_datapath;
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Signals and tables
	logic        sys_clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack, irq;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat_wr, wb_dat_rd, rv, rw, seed;
	logic [63:0] res, a, b;
	int          fail_count, compares, fi;
	// Compare cases: operands, code, {snan flag, compare flag}, enable
	logic [63:0] ca[6] = '{64'h3FF0_0000_0000_0000, 64'h4000_0000_0000_0000, 64'hBFF0_0000_0000_0000,
		`QNAN_DEF, 64'h7FF0_0000_0000_0001, 64'h3FF0_0000_0000_0000};
	logic [63:0] cb[6] = '{64'h4000_0000_0000_0000, 64'h3FF0_0000_0000_0000, 64'hBFF0_0000_0000_0000,
		64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000, 64'h7FF0_0000_0000_0001};
	logic [3:0]  cc[6] = '{`CC_LT, `CC_GT, `CC_EQ, `CC_UN, `CC_UN, `CC_UN};
	logic [1:0]  cf[6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
	logic        ve[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	// Add corner cases: {op, rounding}, operands, result, class
	logic [3:0]  md[8] = '{4'h4, 4'h4, 4'h4, 4'h6, 4'hA, 4'h5, 4'h4, 4'h7};
	logic [63:0] aa[8] = '{64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000,
		64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000, 64'hBFF0_0000_0000_0000,
		64'h3FF0_0000_0000_0000, 64'hBFF0_0000_0000_0000};
	logic [63:0] ab[8] = '{64'h3FF0_0000_0000_0000, 64'hBFE0_0000_0000_0000, 64'h3CA0_0000_0000_0000,
		64'h3CA0_0000_0000_0000, 64'h3E10_0000_0000_0000, 64'hBFF0_0000_0000_0000,
		64'hBFF0_0000_0000_0000, 64'hBCA0_0000_0000_0000};
	logic [63:0] ae[8] = '{64'h4000_0000_0000_0000, 64'h3FE0_0000_0000_0000, 64'h3FF0_0000_0000_0000,
		64'h3FF0_0000_0000_0001, 64'h3FF0_0000_2000_0000, 64'hC000_0000_0000_0000,
		64'h0000_0000_0000_0000, 64'hBFF0_0000_0000_0001};
	logic [4:0]  ac[8] = '{`CL_PNORM, `CL_PNORM, `CL_PNORM, `CL_PNORM, `CL_PNORM, `CL_NNORM, `CL_PZERO, `CL_NNORM};
	// ============================================================
	// Design, sequencer model, clock
	fp_add_abs_compare_datapath dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
		.wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd),
		.wb_ack(wb_ack), .irq(irq));
	seq_bus_model bus_u (.sys_clk(sys_clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// ============================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Nearest-even double sum, the simulator's own real arithmetic
	function automatic logic [63:0] addexp(input logic [63:0] x, input logic [63:0] y);
		return $realtobits($bitstoreal(x) + $bitstoreal(y));
	endfunction
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] t;
		bus_u.xfer(int'(rnd() % 3), 1'b1, ad, d, t);
	endtask
	task automatic rd(input logic [7:0] ad);
		bus_u.xfer(int'(rnd() % 3), 1'b0, ad, 32'h0000_0000, rv);
	endtask
	// Load operands, start, poll busy under a bound, fetch result
	task automatic run(input logic [63:0] x, input logic [63:0] y, input logic [31:0] cmd);
		int n;
		wr(`OFS_OPA_HI, x[63:32]);
		wr(`OFS_OPA_LO, x[31:0]);
		wr(`OFS_OPB_HI, y[63:32]);
		wr(`OFS_OPB_LO, y[31:0]);
		wr(`OFS_CMD, cmd);
		n = 0;
		do begin
			rd(`OFS_STAT);
			n++;
		end while (rv[0] !== 1'b0 && n < 100);
		rd(`OFS_RES_HI);
		res[63:32] = rv;
		rd(`OFS_RES_LO);
		res[31:0] = rv;
	endtask
	task automatic chkirq(input logic e);
		repeat (3) @(posedge sys_clk);
		chk("irq", e, irq);
	endtask
	task automatic summarize();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Watchdog, far beyond the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge sys_clk);
		fail_count++;
		summarize();
	end
	// ============================================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		seed = 32'h0000_0014;
		fail_count = 0;
		compares = 0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(`OFS_FP_STATUS_CONTROL_REG);
		chk("fp_status_control_reg reset", `FP_STATUS_CONTROL_REG_RST, rv);
		rd(`OFS_CR);
		chk("cr reset", `CR_RST, rv);
		rd(8'h30);
		chk("unmapped", 0, rv);
		$display("test reset done");
		// Every compare outcome, random target field
		for (int i = 0; i < 6; i++) begin
			wr(`OFS_FP_STATUS_CONTROL_REG, {24'h0, ve[i], 7'h0});
			fi = int'(rnd() % 8);
			run(ca[i], cb[i], 32'h0000_0003 | (fi << 4));
			rd(`OFS_CR);
			chk("cr field", cc[i], rv[31 - 4 * fi -: 4]);
			rd(`OFS_FP_STATUS_CONTROL_REG);
			chk("cond code", cc[i], rv[15:12]);
			chk("snan flag", cf[i][1], rv[`SIGNALING_NAN_INVALID_FLAG_BIT]);
			chk("cmp flag", cf[i][0], rv[`INVALID_COMPARE_FLAG_BIT]);
		end
		$display("test compare done");
		// Absolute value; field one recorded only with the record bit
		for (int i = 0; i < 9; i++) begin
			if (i == 1) wr(`OFS_FP_STATUS_CONTROL_REG, 32'h0000_0000);
			b = {rnd(), rnd()};
			run(64'h0, b, (i == 0 || i == 8) ? 32'h0000_0004 : 32'h0000_0000);
			chk("abs", b & 64'h7FFF_FFFF_FFFF_FFFF, res);
			rd(`OFS_CR);
			chk("field one", (i == 8) ? 4'h0 : 4'hE, rv[`CR1_HI:`CR1_LO]);
		end
		$display("test abs done");
		// Add corners: carry, cancel, every rounding mode, single
		for (int i = 0; i < 8; i++) begin
			wr(`OFS_FP_STATUS_CONTROL_REG, {30'h0, md[i][1:0]});
			run(aa[i], ab[i], {30'h0, md[i][3:2]});
			chk("add", ae[i], res);
			rd(`OFS_FP_STATUS_CONTROL_REG);
			chk("class", ac[i], rv[`RESULT_CLASS_FLAGS_HI:`RESULT_CLASS_FLAGS_LO]);
		end
		wr(`OFS_FP_STATUS_CONTROL_REG, 32'h0000_0000);
		for (int i = 0; i < 12; i++) begin
			rv = rnd();
			rw = rnd();
			a = {rv[31], 11'h3F0 + {6'h00, rv[4:0]}, rv[30:5], rw[25:0]};
			rv = rnd();
			rw = rnd();
			b = {rv[31], 11'h3F0 + {6'h00, rv[4:0]}, rv[30:5], rw[25:0]};
			run(a, b, 32'h0000_0001);
			chk("rand add", addexp(a, b), res);
		end
		$display("test add done");
		// Interrupt: raise, mask, clear
		wr(`OFS_IRQ_ST, 32'h0000_0003);
		wr(`OFS_IRQ_MASK, 32'h0000_0001);
		run(64'h0, 64'h0, 32'h0000_0000);
		chkirq(1'b1);
		wr(`OFS_IRQ_MASK, 32'h0000_0000);
		chkirq(1'b0);
		wr(`OFS_IRQ_MASK, 32'h0000_0001);
		chkirq(1'b1);
		wr(`OFS_IRQ_ST, 32'h0000_0001);
		chkirq(1'b0);
		$display("test irq done");
		summarize();
	end
endmodule
